// ---- verilog/gbm_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef GBM_REGS_SVH
`define GBM_REGS_SVH

`define GBM_A_CMD      8'h00
`define GBM_A_STATUS   8'h04
`define GBM_A_LINES    8'h08
`define GBM_A_CONFIG   8'h0c
`define GBM_A_IDENT    8'h10
`define GBM_A_RAM      8'h14
`define GBM_A_LISTEN   8'h18

`define GBM_F_OP       0
`define GBM_F_ARG      4
`define GBM_F_BOOL     5
`define GBM_F_PRI      8
`define GBM_F_SEC      16
`define GBM_F_SECV     24

`define GBM_S_BUSY     0
`define GBM_S_CODE     1
`define GBM_S_SHADOW   3
`define GBM_S_IST      4
`define GBM_S_NIC      5
`define GBM_S_NSC      6
`define GBM_S_HOLD     7
`define GBM_S_ONLINE   8
`define GBM_S_SYSCTL   9
`define GBM_S_REN      10

`define GBM_C_EOS      0
`define GBM_C_REOS     8
`define GBM_C_BIN      9
`define GBM_C_SCD      10

`define GBM_CFG_RST    11'h000
// arbitrary identification value
`define GBM_IDENT_VAL  32'h0000_a5c3
`define GBM_RAM_BYTES  32'h0004_0000

`define GBM_ADDR_ALL   8'hff
`define GBM_SEC_MAX    5'h1e
`define GBM_UNL        8'h3f
`define GBM_GTL        8'h01
`define GBM_LAG        3'h1
`define GBM_SCG        3'h3

`define GBM_CLK_NS       8
`define GBM_T_IFC_US     100
`define GBM_T_RENOFF_US  100
`define GBM_T_SETTLE_NS  2000
`define GBM_IFC_CYC \
   ((`GBM_T_IFC_US * 1000 + `GBM_CLK_NS - 1) / `GBM_CLK_NS)
`define GBM_RENOFF_CYC \
   ((`GBM_T_RENOFF_US * 1000 + `GBM_CLK_NS - 1) / `GBM_CLK_NS)
`define GBM_SETTLE_CYC \
   ((`GBM_T_SETTLE_NS + `GBM_CLK_NS - 1) / `GBM_CLK_NS)

`endif

// ---- verilog/gbm_pkg.sv ----
// types shared by the bus management command block
package gbm_pkg;
   typedef enum logic [1:0] {CTL_IDLE, CTL_ACTIVE, CTL_STANDBY} gbm_ctl_t;
   typedef enum logic [3:0] {OP_NONE, OP_GTS, OP_IST, OP_LISTEN_CHK,
                             OP_LOC, OP_ONL, OP_SEND} gbm_op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_IFC, ST_RETAKE, ST_GO, ST_SEQ,
                             ST_HSW, ST_PROBE, ST_RENOFF} gbm_fsm_t;
   typedef enum logic [1:0] {H_IDLE, H_RDY, H_SETTLE, H_DAV} gbm_hfsm_t;

   typedef struct packed {
      gbm_fsm_t        st;
      gbm_ctl_t        cs;
      gbm_op_t         op;
      logic            shadow;
      logic            holdoff;
      logic            ist;
      logic            online;
      logic            ren;
      logic            ifc;
      logic            atn;
      logic            nrfd;
      logic            ndac;
      logic            nic_err;
      logic            nsc_err;
      logic            rtl;
      logic            hs_go;
      logic [7:0]      eos;
      logic            reos;
      logic            bin;
      logic            scd;
      logic [15:0]     cnt;
      logic [3:0][7:0] seq;
      logic [2:0]      seq_n;
      logic [2:0]      seq_i;
      logic [4:0]      pa;
      logic [4:0]      sa;
      logic            sweep;
      logic            secv;
      logic [31:0]     found;
      logic [31:0]     prdata;
   } gbm_core_t;

   typedef struct packed {
      gbm_hfsm_t  st;
      logic [7:0] data;
      logic       dav;
      logic       drive;
      logic       done;
      logic [8:0] cnt;
   } gbm_hs_t;
endpackage : gbm_pkg

// ---- verilog/gbm_hs_if.sv ----
// carrier between the command core and the source handshake engine
`timescale 1ns/10ps
interface gbm_hs_if;
   logic       start;
   logic [7:0] cmd_byte;
   logic       nrfd_a;
   logic       ndac_a;
   logic       done;
   logic       dav;
   logic       drive;
   logic [7:0] dout;
   modport ctl (output start, cmd_byte, nrfd_a, ndac_a,
                input  done, dav, drive, dout);
   modport eng (input  start, cmd_byte, nrfd_a, ndac_a,
                output done, dav, drive, dout);
endinterface : gbm_hs_if

// ---- verilog/gbm_src_hs.sv ----
// three-wire source handshake for one command byte
`timescale 1ns/10ps
`include "gbm_regs.svh"
module gbm_src_hs
   import gbm_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   gbm_hs_if.eng    hs
);
   gbm_hs_t r;
   gbm_hs_t n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      unique case (r.st)
         H_IDLE: begin
            if (hs.start) begin
               n.data = hs.cmd_byte;
               n.st   = H_RDY;
            end
         end
         H_RDY: begin
            if (!hs.nrfd_a) begin
               // nobody holding either line: no acceptor, give up
               if (!hs.ndac_a) begin
                  n.done = 1'b1;
                  n.st   = H_IDLE;
               end else begin
                  n.drive = 1'b1;
                  n.cnt   = 9'(`GBM_SETTLE_CYC);
                  n.st    = H_SETTLE;
               end
            end
         end
         H_SETTLE: begin
            if (r.cnt == 9'h000) begin
               n.dav = 1'b1;
               n.st  = H_DAV;
            end else begin
               n.cnt = r.cnt - 9'h001;
            end
         end
         H_DAV: begin
            if (!hs.ndac_a) begin
               n.dav   = 1'b0;
               n.drive = 1'b0;
               n.done  = 1'b1;
               n.st    = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '{st: H_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign hs.done  = r.done;
   assign hs.dav   = r.dav;
   assign hs.drive = r.drive;
   assign hs.dout  = r.data;

   AST_HS_DATA: assert property (@(posedge clk) disable iff (srst)
      hs.dav |-> hs.drive && $stable(hs.dout))
      else $error("command byte changed while DAV asserted");
endmodule : gbm_src_hs

// ---- verilog/gbm_cmd_core.sv ----
// bus management command core with APB register access
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "gbm_regs.svh"
module gbm_cmd_core
   import gbm_pkg::*;
#(
   parameter int unsigned IFC_CYC    = `GBM_IFC_CYC,
   parameter int unsigned RENOFF_CYC = `GBM_RENOFF_CYC
)(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  ctl_n_i,
   output logic      [7:0]  ctl_n_o,
   output logic      [7:0]  ctl_n_oe_n,
   input  wire logic [7:0]  dio_n_i,
   output logic      [7:0]  dio_n_o,
   output logic      [7:0]  dio_n_oe_n,
   output logic             ist_bit,
   output logic             rtl_pulse
);
   localparam gbm_core_t RST = '{st: ST_IDLE, cs: CTL_IDLE, op: OP_NONE,
                                 online: 1'b1, default: '0};

   gbm_core_t   r;
   gbm_core_t   n;
   gbm_hs_if    u_if ();

   logic        mapped;
   logic        wr_acc;
   logic        cmd_go;
   gbm_op_t     op_w;
   logic        w_arg;
   logic        w_bool;
   logic [7:0]  w_pri;
   logic [7:0]  w_sec;
   logic        w_secv;
   logic [7:0]  bus_dat;
   logic        eos_hit;
   logic        ctl_op;
   logic [31:0] sv;
   logic [31:0] rd_val;

   assign op_w   = gbm_op_t'(pwdata[`GBM_F_OP +: 4]);
   assign w_arg  = pwdata[`GBM_F_ARG];
   assign w_bool = pwdata[`GBM_F_BOOL];
   assign w_pri  = pwdata[`GBM_F_PRI +: 8];
   assign w_sec  = pwdata[`GBM_F_SEC +: 8];
   assign w_secv = pwdata[`GBM_F_SECV];

   assign mapped = (paddr == `GBM_A_CMD)   || (paddr == `GBM_A_STATUS) ||
                   (paddr == `GBM_A_LINES) || (paddr == `GBM_A_CONFIG) ||
                   (paddr == `GBM_A_IDENT) || (paddr == `GBM_A_RAM)    ||
                   (paddr == `GBM_A_LISTEN);
   assign wr_acc  = psel && penable && pwrite && mapped;
   // commands written while busy are dropped; poll the busy bit first
   assign cmd_go  = wr_acc && (paddr == `GBM_A_CMD) && (r.st == ST_IDLE);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign ctl_op  = (op_w == OP_SEND) || ((op_w == OP_LISTEN_CHK) && w_arg)
                    || ((op_w == OP_LOC) && w_arg && (w_pri != `GBM_ADDR_ALL));

   assign bus_dat = ~dio_n_i;
   assign eos_hit = r.reos && (r.bin ? (bus_dat == r.eos) :
                    (bus_dat[6:0] == r.eos[6:0]));

   always_comb begin
      sv = '0;
      sv[`GBM_S_BUSY]      = (r.st != ST_IDLE);
      sv[`GBM_S_CODE +: 2] = r.cs;
      sv[`GBM_S_SHADOW]    = r.shadow;
      sv[`GBM_S_IST]       = r.ist;
      sv[`GBM_S_NIC]       = r.nic_err;
      sv[`GBM_S_NSC]       = r.nsc_err;
      sv[`GBM_S_HOLD]      = r.holdoff;
      sv[`GBM_S_ONLINE]    = r.online;
      sv[`GBM_S_SYSCTL]    = !r.scd;
      sv[`GBM_S_REN]       = r.ren;
   end

   always_comb begin
      rd_val = '0;
      unique case (paddr)
         `GBM_A_STATUS: rd_val = sv;
         // a line we drive ourselves cannot show the others' level
         `GBM_A_LINES:  rd_val = {16'h0000, ctl_n_oe_n, ~ctl_n_i};
         `GBM_A_CONFIG: rd_val = {21'h000000, r.scd, r.bin, r.reos, r.eos};
         `GBM_A_IDENT:  rd_val = `GBM_IDENT_VAL;
         `GBM_A_RAM:    rd_val = `GBM_RAM_BYTES;
         `GBM_A_LISTEN: rd_val = r.found;
         default:       rd_val = '0;
      endcase
   end

   always_comb begin
      n = r;
      n.rtl   = 1'b0;
      n.hs_go = 1'b0;
      if (psel && !penable && !pwrite) begin
         n.prdata = rd_val;
      end
      // clears first so that a same-cycle error set wins
      if (wr_acc && (paddr == `GBM_A_STATUS)) begin
         if (pwdata[`GBM_S_NIC]) n.nic_err = 1'b0;
         if (pwdata[`GBM_S_NSC]) n.nsc_err = 1'b0;
      end
      if (wr_acc && (paddr == `GBM_A_CONFIG)) begin
         n.eos  = pwdata[`GBM_C_EOS +: 8];
         n.reos = pwdata[`GBM_C_REOS];
         n.bin  = pwdata[`GBM_C_BIN];
         n.scd  = pwdata[`GBM_C_SCD];
      end
      // shadow acceptor: takes part in the handshake, never keeps data
      if ((r.cs == CTL_STANDBY) && r.shadow) begin
         if (!ctl_n_i[0]) begin
            n.nrfd = 1'b1;
            if (r.ndac) begin
               if (!ctl_n_i[7] || eos_hit) n.holdoff = 1'b1;
               n.ndac = 1'b0;
            end
         end else begin
            n.ndac = 1'b1;
            n.nrfd = r.holdoff;
         end
      end
      unique case (r.st)
         ST_IDLE: begin
            if (cmd_go) begin
               n.op    = op_w;
               n.pa    = w_pri[4:0];
               n.secv  = w_secv;
               n.sweep = w_secv && (w_sec == `GBM_ADDR_ALL);
               n.sa    = n.sweep ? 5'h00 : w_sec[4:0];
               n.seq[0] = w_pri;
               if ((op_w == OP_GTS) && w_arg) begin
                  if (r.cs == CTL_IDLE) begin
                     n.nic_err = 1'b1;
                  end else begin
                     n.cs      = CTL_STANDBY;
                     n.atn     = 1'b0;
                     n.shadow  = w_bool;
                     n.holdoff = 1'b0;
                     n.nrfd    = 1'b0;
                     n.ndac    = w_bool;
                  end
               end else if ((op_w == OP_IST) && w_arg) begin
                  n.ist = w_bool;
               end else if ((op_w == OP_ONL) && w_arg) begin
                  if (w_bool) begin
                     n = RST;
                     n.prdata = r.prdata;
                  end else begin
                     n.online = 1'b0;
                     n.atn    = 1'b0;
                     n.ren    = 1'b0;
                     n.nrfd   = 1'b0;
                     n.ndac   = 1'b0;
                     n.cs     = CTL_IDLE;
                  end
               end else if ((op_w == OP_LOC) && w_arg &&
                            (w_pri == `GBM_ADDR_ALL)) begin
                  n.rtl = 1'b1;
               end else if ((op_w == OP_LOC) && !w_arg) begin
                  if (r.scd || !r.online) begin
                     n.nsc_err = 1'b1;
                  end else begin
                     n.ren = 1'b0;
                     n.cnt = 16'(RENOFF_CYC);
                     n.st  = ST_RENOFF;
                  end
               end else if (ctl_op) begin
                  if (op_w == OP_LISTEN_CHK) n.found = '0;
                  if (r.cs == CTL_IDLE) begin
                     // no IFC possible when offline or not system controller (scd set)
                     if (r.online && !r.scd) begin
                        n.ifc = 1'b1;
                        n.ren = 1'b1;
                        n.cnt = 16'(IFC_CYC);
                        n.st  = ST_IFC;
                     end else begin
                        n.nic_err = 1'b1;
                     end
                  end else if (r.cs == CTL_STANDBY) begin
                     // holdoff keeps NRFD low, so no byte is in flight
                     n.atn = 1'b1;
                     n.cnt = 16'(`GBM_SETTLE_CYC);
                     n.st  = ST_RETAKE;
                  end else begin
                     n.st = ST_GO;
                  end
               end
            end
         end
         ST_IFC: begin
            if (r.cnt == 16'h0000) begin
               n.ifc = 1'b0;
               n.cs  = CTL_ACTIVE;
               n.atn = 1'b1;
               n.st  = ST_GO;
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
         ST_RETAKE: begin
            if (r.cnt == 16'h0000) begin
               n.nrfd    = 1'b0;
               n.ndac    = 1'b0;
               n.holdoff = 1'b0;
               n.shadow  = 1'b0;
               n.cs      = CTL_ACTIVE;
               n.st      = ST_GO;
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
         ST_GO: begin
            n.seq_i = 3'h0;
            n.st    = ST_SEQ;
            if (r.op == OP_SEND) begin
               n.seq_n = 3'h1;
            end else if (r.op == OP_LOC) begin
               n.seq[0] = {`GBM_LAG, r.pa};
               n.seq[1] = r.secv ? {`GBM_SCG, r.sa} : `GBM_GTL;
               n.seq[2] = r.secv ? `GBM_GTL : `GBM_UNL;
               n.seq[3] = `GBM_UNL;
               n.seq_n  = r.secv ? 3'h4 : 3'h3;
            end else begin
               n.seq[0] = `GBM_UNL;
               n.seq[1] = {`GBM_LAG, r.pa};
               n.seq[2] = {`GBM_SCG, r.sa};
               n.seq_n  = r.secv ? 3'h3 : 3'h2;
            end
         end
         ST_SEQ: begin
            if (r.seq_i == r.seq_n) begin
               if (r.op == OP_LISTEN_CHK) begin
                  n.atn = 1'b0;
                  n.cnt = 16'(`GBM_SETTLE_CYC);
                  n.st  = ST_PROBE;
               end else begin
                  n.op = OP_NONE;
                  n.st = ST_IDLE;
               end
            end else begin
               n.hs_go = 1'b1;
               n.st    = ST_HSW;
            end
         end
         ST_HSW: begin
            if (u_if.done) begin
               n.seq_i = r.seq_i + 3'h1;
               n.st    = ST_SEQ;
            end
         end
         ST_PROBE: begin
            if (r.cnt == 16'h0000) begin
               // an addressed listener keeps NDAC low once ATN drops
               if (!ctl_n_i[1]) begin
                  if (r.sweep) n.found[r.sa] = 1'b1;
                  else n.found[31] = 1'b1;
               end
               n.atn   = 1'b1;
               n.seq_i = 3'h0;
               n.st    = ST_SEQ;
               if (r.sweep && (r.sa != `GBM_SEC_MAX)) begin
                  n.sa     = r.sa + 5'h01;
                  n.seq[2] = {`GBM_SCG, r.sa + 5'h01};
               end else begin
                  n.seq[0] = `GBM_UNL;
                  n.seq_n  = 3'h1;
                  n.op     = OP_SEND;
               end
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
         ST_RENOFF: begin
            if (r.cnt == 16'h0000) begin
               n.ren = 1'b1;
               n.st  = ST_IDLE;
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   assign u_if.start    = r.hs_go;
   assign u_if.cmd_byte = r.seq[r.seq_i[1:0]];
   assign u_if.nrfd_a   = ~ctl_n_i[2];
   assign u_if.ndac_a   = ~ctl_n_i[1];

   gbm_src_hs u_hs (
      .clk  (clk),
      .srst (srst),
      .hs   (u_if.eng)
   );

   // open-drain: level is always low, enable decides
   assign ctl_n_o    = 8'h00;
   assign ctl_n_oe_n = ~{1'b0, r.atn, 1'b0, r.ren, r.ifc,
                         r.nrfd, r.ndac, u_if.dav};
   assign dio_n_o    = 8'h00;
   assign dio_n_oe_n = ~({8{u_if.drive}} & u_if.dout);
   assign prdata     = r.prdata;
   assign ist_bit    = r.ist;
   assign rtl_pulse  = r.rtl;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_GTS_SHADOW: assert property (
      cmd_go && (op_w == OP_GTS) && w_arg && (r.cs != CTL_IDLE)
      |=> r.shadow == $past(w_bool) && ctl_n_oe_n[1] == !$past(w_bool))
      else $error("shadow flag does not follow standby argument");
   AST_GTS_ATN: assert property (
      cmd_go && (op_w == OP_GTS) && w_arg && (r.cs == CTL_ACTIVE)
      |=> r.cs == CTL_STANDBY && ctl_n_oe_n[6])
      else $error("standby did not release ATN");
   AST_HOLD: assert property (
      (r.cs == CTL_STANDBY) && r.shadow && r.holdoff &&
      (r.st == ST_IDLE) && !cmd_go |=> !ctl_n_oe_n[2])
      else $error("holdoff lost NRFD");
   AST_GTS_NIC: assert property (
      cmd_go && (op_w == OP_GTS) && w_arg && (r.cs == CTL_IDLE)
      |=> r.nic_err && r.cs == CTL_IDLE && $stable(ctl_n_oe_n[6:4]))
      else $error("standby while not in charge changed the bus");
   AST_IST: assert property (
      cmd_go && (op_w == OP_IST) && w_arg |=> ist_bit == $past(w_bool))
      else $error("status bit not written");
   AST_IFC: assert property (
      cmd_go && ctl_op && (r.cs == CTL_IDLE) && r.online && !r.scd
      |=> (!ctl_n_oe_n[3] && !ctl_n_oe_n[4]) [*8])
      else $error("IFC and REN not asserted for controller command");
   AST_NOT_CIC: assert property (
      cmd_go && ctl_op && (r.cs == CTL_IDLE) && r.scd
      |=> r.nic_err && r.st == ST_IDLE && ctl_n_oe_n[3])
      else $error("not-in-charge error missing");
   AST_NSC: assert property (
      cmd_go && (op_w == OP_LOC) && !w_arg && r.scd
      |=> r.nsc_err && r.ren == $past(r.ren))
      else $error("not-system-controller error missing");
   AST_RENOFF: assert property (
      cmd_go && (op_w == OP_LOC) && !w_arg && !r.scd && r.online
      |=> ctl_n_oe_n[4] [*8])
      else $error("REN not released for local command");
   AST_RTL: assert property (
      cmd_go && (op_w == OP_LOC) && w_arg && (w_pri == `GBM_ADDR_ALL)
      |=> rtl_pulse ##1 !rtl_pulse)
      else $error("return-to-local pulse wrong");
   AST_ONL: assert property (
      cmd_go && (op_w == OP_ONL) && w_arg && w_bool
      |=> !ist_bit && r.cs == CTL_IDLE && r.online && !r.reos)
      else $error("online did not restore defaults");
   AST_PLAIN_SB: assert property (
      (r.cs == CTL_STANDBY) && !r.shadow |-> ctl_n_oe_n[2:1] == 2'b11)
      else $error("plain standby drives NRFD or NDAC");

   COV_SHADOW: cover property (
      (r.cs == CTL_STANDBY) && r.shadow ##1 r.holdoff);
   COV_IFC: cover property ($rose(r.ifc));
   COV_FOUND: cover property (
      (r.st == ST_PROBE) && (r.cnt == 16'h0000) && !ctl_n_i[1]);
   COV_RETAKE: cover property ((r.st == ST_RETAKE) && r.holdoff);
endmodule : gbm_cmd_core

// ---- sim/gbm_instr_model.sv ----
// bus instrument model: slow acceptor holding ndac, plus a plain talker
`timescale 1ns/10ps
module gbm_instr_model (
   input  wire logic       clk,
   input  wire logic [7:0] ctl_n,
   input  wire logic       tk_go,
   input  wire logic [7:0] tk_byte,
   output logic      [7:0] ctl_oe_n,
   output logic      [7:0] dio_oe_n,
   output logic            tk_busy
);
   logic [1:0] dly_r;
   logic [1:0] tk_r = 2'h0;
   logic [7:0] tk_d;
   // ndac lets go only after dav has stood a few cycles, like slow parts
   always_ff @(posedge clk) begin
      if (ctl_n[0])
         dly_r <= 2'h0;
      else if (dly_r != 2'h3)
         dly_r <= dly_r + 2'h1;
   end
   // talker: wait for nrfd high, show byte and dav, wait for ndac high
   always_ff @(posedge clk) begin
      if (tk_go) begin
         tk_r <= 2'h1;
         tk_d <= tk_byte;
      end else if ((tk_r == 2'h1) && ctl_n[2]) begin
         tk_r <= 2'h2;
      end else if ((tk_r == 2'h2) && ctl_n[1]) begin
         tk_r <= 2'h0;
      end
   end
   assign tk_busy  = (tk_r != 2'h0);
   assign dio_oe_n = (tk_r == 2'h2) ? ~tk_d : 8'hff;
   assign ctl_oe_n = {6'h3f, dly_r == 2'h3, tk_r != 2'h2};
endmodule : gbm_instr_model

// ---- sim/gbm_tb.sv ----
// bench for the bus management command core
`timescale 1ns/10ps
`include "gbm_regs.svh"
module gpib_bus_management_cmds_tb_top;
   import gbm_pkg::*;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, re, pready, pslverr, ist_bit, rtl_pulse;
   logic [7:0]  paddr = 8'h00, ctl_oe_n, m_oe_n, dio_oe_n, ctl_n;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   logic        saw_ifc = 1'b0, tk_go = 1'b0, tk_busy, dav_q = 1'b1;
   logic [7:0]  tk_byte = 8'h00, t_dio_n, dio_n;
   logic [23:0] cmd_log = 24'h000000;
   int          fails = 0, num_checks = 0;
   assign ctl_n = ctl_oe_n & m_oe_n;
   always #4 clk = ~clk;
   always @(posedge clk) if (ctl_n[3] === 1'b0) saw_ifc <= 1'b1;
   assign dio_n = dio_oe_n & t_dio_n;
   // shift in each byte as dav falls
   always @(posedge clk) begin
      dav_q <= ctl_n[0];
      if (dav_q && !ctl_n[0]) cmd_log <= {cmd_log[15:0], ~dio_n};
   end
   gbm_cmd_core #(.IFC_CYC(20), .RENOFF_CYC(20)) i_dut (.clk(clk),
      .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ctl_n_i(ctl_n), .ctl_n_o(), .ctl_n_oe_n(ctl_oe_n),
      .dio_n_i(dio_n), .dio_n_o(), .dio_n_oe_n(dio_oe_n),
      .ist_bit(ist_bit), .rtl_pulse(rtl_pulse));
   gbm_instr_model i_mdl (.clk(clk), .ctl_n(ctl_n), .tk_go(tk_go),
      .tk_byte(tk_byte), .ctl_oe_n(m_oe_n), .dio_oe_n(t_dio_n),
      .tk_busy(tk_busy));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, s, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         fails++;
         give_verdict();
      end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rq, x);
   endtask : rd
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, `GBM_A_STATUS, 32'h0);
         n++;
      // a full secondary sweep runs for some 32k cycles
      end while (rq[0] !== 1'b0 && n < 12000);
      if (n == 12000) begin
         fails++;
         give_verdict();
      end
   endtask : wait_idle
   task automatic talk(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk);
      tk_byte <= b;
      tk_go <= 1'b1;
      @(posedge clk);
      tk_go <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (tk_busy === 1'b1 && n < 50);
      if (n == 50) begin
         fails++;
         give_verdict();
      end
   endtask : talk
   task automatic t_reset;
      rd(`GBM_A_IDENT, `GBM_IDENT_VAL);
      rd(`GBM_A_RAM, `GBM_RAM_BYTES);
      rd(`GBM_A_STATUS, 32'h0000_0300);
      rd(8'h1c, 32'h0);
      chk(re, 1'b1);
   endtask : t_reset
   task automatic t_gts_idle;
      apb(1'b1, `GBM_A_CMD, 32'h0000_0031);
      rd(`GBM_A_STATUS, 32'h0000_0320);
      apb(1'b1, `GBM_A_STATUS, 32'h0000_0020);
      rd(`GBM_A_STATUS, 32'h0000_0300);
   endtask : t_gts_idle
   task automatic t_ist_rtl;
      apb(1'b1, `GBM_A_CMD, 32'h0000_0032);
      #1 chk(ist_bit, 1'b1);
      rd(`GBM_A_STATUS, 32'h0000_0310);
      apb(1'b1, `GBM_A_CMD, 32'h0000_ff14);
      #1 chk(rtl_pulse, 1'b1);
      @(posedge clk);
      #1 chk(rtl_pulse, 1'b0);
      chk(ist_bit, 1'b1);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0012);
      #1 chk(ist_bit, 1'b0);
   endtask : t_ist_rtl
   task automatic t_ctl;
      apb(1'b1, `GBM_A_CMD, 32'h0000_3f06);
      wait_idle();
      chk(saw_ifc, 1'b1);
      chk(rq, 32'h0000_0702);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0011);
      rd(`GBM_A_STATUS, 32'h0000_0704);
      chk(ctl_oe_n[6:1], 6'h37);
      // ren self-driven shows in both bytes; ndac held by the instrument
      rd(`GBM_A_LINES, 32'h0000_ef12);
      apb(1'b1, `GBM_A_CONFIG, 32'h0000_010a);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0031);
      rd(`GBM_A_STATUS, 32'h0000_070c);
      talk(8'h41);
      rd(`GBM_A_STATUS, 32'h0000_070c);
      talk(8'h8a);
      rd(`GBM_A_STATUS, 32'h0000_078c);
      chk(ctl_n[2], 1'b0);
      apb(1'b1, `GBM_A_CMD, 32'h0000_3f06);
      wait_idle();
      chk(rq, 32'h0000_0702);
   endtask : t_ctl
   task automatic t_onl;
      apb(1'b1, `GBM_A_CMD, 32'h0000_0032);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0035);
      #1 chk(ist_bit, 1'b0);
      rd(`GBM_A_CONFIG, 32'h0);
      rd(`GBM_A_STATUS, 32'h0000_0300);
   endtask : t_onl
   task automatic t_bus;
      apb(1'b1, `GBM_A_CMD, 32'h0000_0004);
      rd(`GBM_A_STATUS, 32'h0000_0301);
      wait_idle();
      chk(rq, 32'h0000_0700);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0313);
      wait_idle();
      rd(`GBM_A_LISTEN, 32'h8000_0000);
      apb(1'b1, `GBM_A_CMD, 32'h01ff_0313);
      wait_idle();
      rd(`GBM_A_LISTEN, 32'h7fff_ffff);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0314);
      wait_idle();
      chk(cmd_log, {`GBM_LAG, 5'h03, `GBM_GTL, `GBM_UNL});
      apb(1'b1, `GBM_A_CMD, 32'h0000_0035);
      apb(1'b1, `GBM_A_CONFIG, 32'h0000_0400);
      apb(1'b1, `GBM_A_CMD, 32'h0000_0004);
      apb(1'b1, `GBM_A_CMD, 32'h0000_3f06);
      rd(`GBM_A_STATUS, 32'h0000_0160);
   endtask : t_bus
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_gts_idle();
      t_ist_rtl();
      t_ctl();
      t_onl();
      t_bus();
      give_verdict();
   end
endmodule : gpib_bus_management_cmds_tb_top
